// ==== hw/chip_settings_pkg.sv ====
// Constants, codes and types shared by the chip settings readout block
package chip_settings_pkg;
    localparam int         REPORT_LEN      = 64;
    localparam int         IDX_W           = 6;
    localparam logic [7:0] CMD_READ_FLASH  = 8'hb0;
    localparam logic [7:0] SUB_CHIP_SET    = 8'h00;
    localparam logic [7:0] CODE_OK         = 8'h00;
    localparam logic [7:0] CODE_NOT_SUPP   = 8'h01;
    localparam logic [7:0] STRUCT_LEN      = 8'h0a;
    localparam logic [5:0] IDX_CMD         = 6'h00;
    localparam logic [5:0] IDX_CODE        = 6'h01;
    localparam logic [5:0] IDX_LEN         = 6'h02;
    localparam logic [5:0] IDX_PAD         = 6'h03;
    localparam logic [5:0] IDX_SERIAL_LEDS = 6'h04;
    localparam logic [5:0] IDX_CLOCK       = 6'h05;
    localparam logic [5:0] IDX_DAC         = 6'h06;
    localparam logic [5:0] IDX_LAST        = 6'h3f;
    // Byte 4 fields
    localparam int         BIT_SERIAL_EN   = 7;
    localparam int         BIT_RX_IDLE     = 6;
    localparam int         BIT_TX_IDLE     = 5;
    localparam int         BIT_I2C_IDLE    = 4;
    localparam int         BIT_SUSP_IDLE   = 3;
    localparam int         BIT_CFG_IDLE    = 2;
    localparam int         SEC_HI          = 1;
    localparam int         SEC_LO          = 0;
    localparam logic [1:0] SEC_UNSECURED   = 2'h0;
    localparam logic [1:0] SEC_PASSWORD    = 2'h1;
    // Byte 5 and byte 6 fields
    localparam int         DIV_HI          = 4;
    localparam int         DAC_REF_HI      = 7;
    localparam int         DAC_REF_LO      = 6;
    localparam int         BIT_DAC_SRC     = 5;
    localparam int         DAC_CODE_HI     = 4;
    localparam logic [1:0] DAC_REF_OFF     = 2'h0;
    // Register map, byte addresses
    localparam logic [7:0] REG_SERIAL_LEDS = 8'h00;
    localparam logic [7:0] REG_CLOCK       = 8'h04;
    localparam logic [7:0] REG_DAC         = 8'h08;
    localparam logic [7:0] REG_PIN_ENABLE  = 8'h0c;
    localparam logic [7:0] REG_STATUS      = 8'h10;
    localparam logic [7:0] REG_REPLY_COUNT = 8'h14;
    // Pin enable bits
    localparam int         EN_I2C          = 0;
    localparam int         EN_SUSPEND      = 1;
    localparam int         EN_CONFIGURED   = 2;
    localparam int         EN_CLOCK_OUT    = 3;
    // Reset values
    localparam logic [7:0] RST_SERIAL_LEDS = 8'h00;
    localparam logic [7:0] RST_CLOCK       = 8'h00;
    localparam logic [7:0] RST_DAC         = 8'h00;
    localparam logic [3:0] RST_PIN_ENABLE  = 4'h0;
    // Synchronised pin inputs
    localparam int         SYN_RX          = 0;
    localparam int         SYN_TX          = 1;
    localparam int         SYN_I2C         = 2;
    localparam int         SYN_SUSPEND     = 3;
    localparam int         SYN_CONFIGURED  = 4;
    localparam int         SYN_CLK48       = 5;
    localparam int         SYN_W           = 6;

    typedef enum logic [0:0] {
        ST_IDLE,
        ST_REPLY
    } state_t;
endpackage

// ==== hw/settings_reply_if.sv ====
// Carrier between the reply sequencer and the reply byte formatter
`timescale 1ns/1ns
interface settings_reply_if;
    logic [5:0] index;
    logic       supported;
    logic [7:0] serial_leds;
    logic [7:0] clock_div;
    logic [7:0] dac_cfg;
    logic [7:0] reply_byte;

    modport sequencer (output index, output supported, output serial_leds, output clock_div,
                       output dac_cfg, input reply_byte);
    modport formatter (input index, input supported, input serial_leds, input clock_div,
                       input dac_cfg, output reply_byte);
endinterface

// ==== hw/settings_reply_format.sv ====
// Combinational formatter of one reply byte by index
`timescale 1ns/1ns
module settings_reply_format (
    settings_reply_if.formatter rpl
);
    always_comb begin
        rpl.reply_byte = 8'h00;
        unique case (rpl.index)
            chip_settings_pkg::IDX_CMD: begin
                rpl.reply_byte = chip_settings_pkg::CMD_READ_FLASH;
            end
            chip_settings_pkg::IDX_CODE: begin
                rpl.reply_byte = rpl.supported ? chip_settings_pkg::CODE_OK
                                               : chip_settings_pkg::CODE_NOT_SUPP;
            end
            chip_settings_pkg::IDX_LEN: begin
                if (rpl.supported) begin
                    rpl.reply_byte = chip_settings_pkg::STRUCT_LEN;
                end
            end
            chip_settings_pkg::IDX_SERIAL_LEDS: begin
                if (rpl.supported) begin
                    rpl.reply_byte = rpl.serial_leds;
                end
            end
            chip_settings_pkg::IDX_CLOCK: begin
                if (rpl.supported) begin
                    rpl.reply_byte = {3'h0, rpl.clock_div[chip_settings_pkg::DIV_HI:0]};
                end
            end
            chip_settings_pkg::IDX_DAC: begin
                if (rpl.supported) begin
                    rpl.reply_byte = rpl.dac_cfg;
                end
            end
            default: begin
                rpl.reply_byte = 8'h00;
            end
        endcase
    end
endmodule

// ==== hw/chip_settings_readout.sv ====
// Chip settings readout: request parsing, settings registers, indicator pins, clock output
`timescale 1ns/1ns
module chip_settings_readout (
    input  wire logic       clk_sys_in,
    input  wire logic       sys_rst_in,
    // Register port
    input  wire logic [7:0] reg_addr_in,
    input  wire logic [31:0] reg_wdata_in,
    input  wire logic       reg_wr_in,
    input  wire logic       reg_rd_in,
    output logic      [31:0] reg_rdata_out,
    // Request report, one byte per cycle
    input  wire logic       req_valid_in,
    input  wire logic [5:0] req_index_in,
    input  wire logic [7:0] req_byte_in,
    output logic            req_ready_out,
    // Reply report, one byte per cycle
    output logic            rsp_valid_out,
    output logic      [5:0] rsp_index_out,
    output logic      [7:0] rsp_byte_out,
    // Activity and state pins from outside
    input  wire logic       uart_rx_busy_in,
    input  wire logic       uart_tx_busy_in,
    input  wire logic       i2c_busy_in,
    input  wire logic       suspend_in,
    input  wire logic       usb_configured_in,
    input  wire logic       usb_clk_48_in,
    // Indicator and clock pins
    output logic            uart_rx_activity_indicator_out,
    output logic            uart_tx_activity_indicator_out,
    output logic            i2c_activity_indicator_out,
    output logic            suspend_indicator_out,
    output logic            usb_configured_indicator_out,
    output logic            general_purpose_pin_clock_out,
    output logic            general_purpose_pin_clock_oe_out
);
    typedef struct packed {
        chip_settings_pkg::state_t state;
        logic [5:0]                cnt;
        logic [7:0]                cmd;
        logic [7:0]                sub;
        logic                      supported;
        logic [7:0]                serial_leds;
        logic [7:0]                clock_div;
        logic [7:0]                dac_cfg;
        logic [3:0]                pin_en;
        logic [31:0]               rd_data;
        logic                      rsp_valid;
        logic [5:0]                rsp_index;
        logic [7:0]                rsp_byte;
        logic [5:0]                sync1;
        logic [5:0]                sync2;
        logic                      clk48_prev;
        logic [4:0]                div_cnt;
        logic                      clk_out;
        logic [4:0]                ind;
        logic [15:0]               reply_count;
    } state_all_t;

    state_all_t s;
    state_all_t next_s;

    settings_reply_if rpl ();

    settings_reply_format u_format (
        .rpl (rpl)
    );

    assign rpl.index       = s.cnt;
    assign rpl.supported   = s.supported;
    assign rpl.serial_leds = s.serial_leds;
    assign rpl.clock_div   = s.clock_div;
    assign rpl.dac_cfg     = s.dac_cfg;

    // Security field 10 or 11 means permanently locked
    function automatic logic is_locked(input logic [7:0] leds);
        is_locked = leds[chip_settings_pkg::SEC_HI];
    endfunction

    function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] reg_off);
        addr_is = (addr == reg_off);
    endfunction

    // Indicator level: idle level, inverted while the condition holds and the pin is enabled
    function automatic logic drive_ind(input logic idle, input logic active, input logic en);
        drive_ind = idle ^ (active & en);
    endfunction

    logic [4:0] div_val;
    logic       clk48_rise;
    logic       wr_cfg_ok;

    always_comb begin
        div_val    = s.clock_div[chip_settings_pkg::DIV_HI:0];
        clk48_rise = s.sync2[chip_settings_pkg::SYN_CLK48] & ~s.clk48_prev;
        wr_cfg_ok  = reg_wr_in & ~is_locked(s.serial_leds);
    end

    always_comb begin
        next_s = s;

        // Two-flop synchronisers for every pin input
        next_s.sync1 = {usb_clk_48_in, usb_configured_in, suspend_in, i2c_busy_in,
                        uart_tx_busy_in, uart_rx_busy_in};
        next_s.sync2 = s.sync1;
        next_s.clk48_prev = s.sync2[chip_settings_pkg::SYN_CLK48];

        // Register writes; locked settings refuse changes
        if (wr_cfg_ok && addr_is(reg_addr_in, chip_settings_pkg::REG_SERIAL_LEDS)) begin
            next_s.serial_leds = reg_wdata_in[7:0];
        end
        if (wr_cfg_ok && addr_is(reg_addr_in, chip_settings_pkg::REG_CLOCK)) begin
            next_s.clock_div = {3'h0, reg_wdata_in[chip_settings_pkg::DIV_HI:0]};
        end
        if (wr_cfg_ok && addr_is(reg_addr_in, chip_settings_pkg::REG_DAC)) begin
            next_s.dac_cfg = reg_wdata_in[7:0];
        end
        if (reg_wr_in && addr_is(reg_addr_in, chip_settings_pkg::REG_PIN_ENABLE)) begin
            next_s.pin_en = reg_wdata_in[3:0];
        end

        // Register reads, data in the following cycle only
        next_s.rd_data = 32'h0000_0000;
        if (reg_rd_in) begin
            unique case (reg_addr_in)
                chip_settings_pkg::REG_SERIAL_LEDS: begin
                    next_s.rd_data = {24'h00_0000, s.serial_leds};
                end
                chip_settings_pkg::REG_CLOCK: begin
                    next_s.rd_data = {24'h00_0000, s.clock_div};
                end
                chip_settings_pkg::REG_DAC: begin
                    next_s.rd_data = {24'h00_0000, s.dac_cfg};
                end
                chip_settings_pkg::REG_PIN_ENABLE: begin
                    next_s.rd_data = {28'h000_0000, s.pin_en};
                end
                chip_settings_pkg::REG_STATUS: begin
                    next_s.rd_data = {16'h0000, 3'h0, s.sync2[chip_settings_pkg::SYN_CONFIGURED:0],
                                      s.clk_out, s.ind, is_locked(s.serial_leds),
                                      s.state == chip_settings_pkg::ST_REPLY};
                end
                chip_settings_pkg::REG_REPLY_COUNT: begin
                    next_s.rd_data = {16'h0000, s.reply_count};
                end
                default: begin
                    next_s.rd_data = 32'h0000_0000;
                end
            endcase
        end

        // Request intake and reply sequencing
        next_s.rsp_valid = 1'b0;
        unique case (s.state)
            chip_settings_pkg::ST_IDLE: begin
                if (req_valid_in) begin
                    if (req_index_in == chip_settings_pkg::IDX_CMD) begin
                        next_s.cmd = req_byte_in;
                    end
                    if (req_index_in == chip_settings_pkg::IDX_CODE) begin
                        next_s.sub = req_byte_in;
                    end
                    if (req_index_in == chip_settings_pkg::IDX_LAST
                        && s.cmd == chip_settings_pkg::CMD_READ_FLASH) begin
                        next_s.state     = chip_settings_pkg::ST_REPLY;
                        next_s.cnt       = 6'h00;
                        next_s.supported = (s.sub == chip_settings_pkg::SUB_CHIP_SET);
                    end
                end
            end
            chip_settings_pkg::ST_REPLY: begin
                next_s.rsp_valid = 1'b1;
                next_s.rsp_index = s.cnt;
                next_s.rsp_byte  = rpl.reply_byte;
                next_s.cnt       = s.cnt + 6'h01;
                if (s.cnt == chip_settings_pkg::IDX_LAST) begin
                    next_s.state       = chip_settings_pkg::ST_IDLE;
                    next_s.cmd         = 8'h00;
                    next_s.sub         = 8'h00;
                    next_s.cnt         = 6'h00;
                    next_s.reply_count = s.reply_count + 16'h0001;
                end
            end
        endcase

        // Indicator pins
        next_s.ind[0] = drive_ind(s.serial_leds[chip_settings_pkg::BIT_RX_IDLE],
                                  s.sync2[chip_settings_pkg::SYN_RX], 1'b1);
        next_s.ind[1] = drive_ind(s.serial_leds[chip_settings_pkg::BIT_TX_IDLE],
                                  s.sync2[chip_settings_pkg::SYN_TX], 1'b1);
        next_s.ind[2] = drive_ind(s.serial_leds[chip_settings_pkg::BIT_I2C_IDLE],
                                  s.sync2[chip_settings_pkg::SYN_I2C],
                                  s.pin_en[chip_settings_pkg::EN_I2C]);
        next_s.ind[3] = drive_ind(s.serial_leds[chip_settings_pkg::BIT_SUSP_IDLE],
                                  s.sync2[chip_settings_pkg::SYN_SUSPEND],
                                  s.pin_en[chip_settings_pkg::EN_SUSPEND]);
        next_s.ind[4] = drive_ind(s.serial_leds[chip_settings_pkg::BIT_CFG_IDLE],
                                  s.sync2[chip_settings_pkg::SYN_CONFIGURED],
                                  s.pin_en[chip_settings_pkg::EN_CONFIGURED]);

        // Clock output: one output period per div_val periods of the 48 MHz clock, or per two periods when div_val is 1
        if (!s.pin_en[chip_settings_pkg::EN_CLOCK_OUT] || div_val == 5'h00) begin
            next_s.div_cnt = 5'h00;
            next_s.clk_out = 1'b0;
        end else if (clk48_rise) begin
            if (s.div_cnt + 5'h01 >= div_val) begin
                next_s.div_cnt = 5'h00;
            end else begin
                next_s.div_cnt = s.div_cnt + 5'h01;
            end
            next_s.clk_out = (s.div_cnt < (div_val >> 1)) || (div_val == 5'h01 && !s.clk_out);
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            s             <= '0;
            s.state       <= chip_settings_pkg::ST_IDLE;
            s.serial_leds <= chip_settings_pkg::RST_SERIAL_LEDS;
            s.clock_div   <= chip_settings_pkg::RST_CLOCK;
            s.dac_cfg     <= chip_settings_pkg::RST_DAC;
            s.pin_en      <= chip_settings_pkg::RST_PIN_ENABLE;
        end else begin
            s <= next_s;
        end
    end

    assign reg_rdata_out                    = s.rd_data;
    assign req_ready_out                    = (s.state == chip_settings_pkg::ST_IDLE);
    assign rsp_valid_out                    = s.rsp_valid;
    assign rsp_index_out                    = s.rsp_index;
    assign rsp_byte_out                     = s.rsp_byte;
    assign uart_rx_activity_indicator_out   = s.ind[0];
    assign uart_tx_activity_indicator_out   = s.ind[1];
    assign i2c_activity_indicator_out       = s.ind[2];
    assign suspend_indicator_out            = s.ind[3];
    assign usb_configured_indicator_out     = s.ind[4];
    assign general_purpose_pin_clock_out    = s.clk_out;
    assign general_purpose_pin_clock_oe_out = s.pin_en[chip_settings_pkg::EN_CLOCK_OUT];
endmodule

// ==== testbench/chip_settings_readout_monitor.sv ====
// Checker of reply framing, reply bytes, register readback and indicator levels
`timescale 1ns/1ns
module chip_settings_readout_monitor (
    input wire logic        clk_sys_in,
    input wire logic        sys_rst_in,
    input wire logic [7:0]  reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic        reg_wr_in,
    input wire logic        reg_rd_in,
    input wire logic [31:0] reg_rdata_out,
    input wire logic        req_valid_in,
    input wire logic [5:0]  req_index_in,
    input wire logic [7:0]  req_byte_in,
    input wire logic        req_ready_out,
    input wire logic        rsp_valid_out,
    input wire logic [5:0]  rsp_index_out,
    input wire logic [7:0]  rsp_byte_out,
    input wire logic        uart_rx_busy_in,
    input wire logic        uart_tx_busy_in,
    input wire logic        uart_rx_activity_indicator_out,
    input wire logic        uart_tx_activity_indicator_out
);
    logic [7:0] cmd_seen;
    logic [7:0] sub_seen;
    logic [7:0] shadow;
    logic [6:0] rsp_run;
    logic [2:0] since_rst;
    logic       taken;

    assign taken = req_valid_in && req_ready_out;

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            cmd_seen <= 8'h00;
            sub_seen <= 8'h00;
            shadow <= 8'h00;
            rsp_run <= 7'h00;
            since_rst <= 3'h0;
        end else begin
            if (taken && req_index_in == 6'h00) cmd_seen <= req_byte_in;
            if (taken && req_index_in == 6'h01) sub_seen <= req_byte_in;
            // Locked states keep the settings byte frozen
            if (reg_wr_in && reg_addr_in == 8'h00 && !shadow[1]) shadow <= reg_wdata_in[7:0];
            rsp_run <= rsp_valid_out ? rsp_run + 7'h01 : 7'h00;
            if (since_rst != 3'h7) since_rst <= since_rst + 3'h1;
        end
    end

    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (sys_rst_in);

    AST_REPLY_START: assert property (taken && req_index_in == 6'h3f && cmd_seen == 8'hb0 |->
        ##2 rsp_valid_out && rsp_index_out == 6'h00 && rsp_byte_out == 8'hb0) else $error("reply start wrong");
    AST_NO_REPLY: assert property (taken && req_index_in == 6'h3f && cmd_seen != 8'hb0 |->
        ##1 !rsp_valid_out [*3]) else $error("reply to foreign command");
    AST_CODE_BYTE: assert property (rsp_valid_out && rsp_index_out == 6'h01 |->
        rsp_byte_out == (sub_seen == 8'h00 ? 8'h00 : 8'h01)) else $error("code byte wrong");
    AST_LEN_BYTE: assert property (rsp_valid_out && rsp_index_out == 6'h02 |->
        rsp_byte_out == (sub_seen == 8'h00 ? 8'h0a : 8'h00)) else $error("length byte wrong");
    AST_SERIAL_BYTE: assert property (rsp_valid_out && rsp_index_out == 6'h04 && sub_seen == 8'h00 |->
        rsp_byte_out == $past(shadow)) else $error("settings byte wrong");
    AST_INDEX_STEP: assert property (rsp_valid_out && $past(rsp_valid_out) |->
        rsp_index_out == $past(rsp_index_out) + 6'h01) else $error("reply index skipped");
    AST_RUN_64: assert property ($fell(rsp_valid_out) |-> rsp_run == 7'd64)
        else $error("reply not 64 bytes");
    AST_READBACK: assert property ($past(reg_rd_in) && $past(reg_addr_in) == 8'h00 |->
        reg_rdata_out == {24'h0, shadow}) else $error("settings readback wrong");
    AST_RX_LEVEL: assert property (since_rst == 3'h7 && $stable(uart_rx_busy_in) &&
        $past(uart_rx_busy_in, 3) == uart_rx_busy_in && $stable(shadow) && $past(shadow, 2) == shadow |->
        uart_rx_activity_indicator_out == (shadow[6] ^ uart_rx_busy_in)) else $error("rx indicator wrong");
    AST_TX_LEVEL: assert property (since_rst == 3'h7 && $stable(uart_tx_busy_in) &&
        $past(uart_tx_busy_in, 3) == uart_tx_busy_in && $stable(shadow) && $past(shadow, 2) == shadow |->
        uart_tx_activity_indicator_out == (shadow[5] ^ uart_tx_busy_in)) else $error("tx indicator wrong");

    COV_REPLY: cover property ($rose(rsp_valid_out));
    COV_UNSUPP: cover property (rsp_valid_out && rsp_index_out == 6'h01 && rsp_byte_out == 8'h01);
    COV_LOCKED_WRITE: cover property (reg_wr_in && reg_addr_in == 8'h00 && shadow[1]);
endmodule

bind chip_settings_readout chip_settings_readout_monitor i_chip_settings_readout_monitor (
    .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .req_valid_in(req_valid_in),
    .req_index_in(req_index_in), .req_byte_in(req_byte_in), .req_ready_out(req_ready_out),
    .rsp_valid_out(rsp_valid_out), .rsp_index_out(rsp_index_out), .rsp_byte_out(rsp_byte_out),
    .uart_rx_busy_in(uart_rx_busy_in), .uart_tx_busy_in(uart_tx_busy_in),
    .uart_rx_activity_indicator_out(uart_rx_activity_indicator_out),
    .uart_tx_activity_indicator_out(uart_tx_activity_indicator_out));

// ==== testbench/host_model.sv ====
// Host side model that sends one 64-byte request report per start pulse
`timescale 1ns/1ns
module host_model (
    input  wire logic       clk_sys_in,
    input  wire logic       start_in,
    input  wire logic [7:0] cmd_in,
    input  wire logic [7:0] sub_in,
    input  wire logic       ready_in,
    output logic            valid_out,
    output logic      [5:0] index_out,
    output logic      [7:0] byte_out
);
    initial begin
        valid_out = 1'b0;
        index_out = 6'h00;
        byte_out = 8'h00;
    end

    always @(posedge clk_sys_in) begin
        if (valid_out && ready_in) begin
            if (index_out == 6'h3f) begin
                valid_out <= 1'b0;
                byte_out <= ~byte_out;
            end else begin
                index_out <= index_out + 6'h01;
                byte_out <= (index_out == 6'h00) ? sub_in : 8'h00;
            end
        end else if (start_in && !valid_out) begin
            valid_out <= 1'b1;
            index_out <= 6'h00;
            byte_out <= cmd_in;
        end else if (!valid_out) begin
            // Released data lines show no stale value
            byte_out <= ~byte_out;
        end
    end
endmodule

// ==== testbench/chip_settings_readout_test.sv ====
// Self-checking bench for the chip settings readout block
`timescale 1ns/1ns
module chip_settings_readout_test;
    logic        clk_sys_in, sys_rst_in, clk48, reg_wr, reg_rd, start, req_valid, req_ready, rsp_valid;
    logic        gp_clk, gp_oe;
    logic [7:0]  reg_addr, cmd, sub, req_byte, rsp_byte;
    logic [31:0] reg_wdata, reg_rdata;
    logic [5:0]  req_index, rsp_index;
    logic [4:0]  busy, ind;
    logic [31:0] reply [64];
    int          rsp_total = 0;
    int          cycles = 0;
    int          failures = 0;
    int          checked = 0;

    initial begin
        clk_sys_in = 1'b0;
        forever #2 clk_sys_in = ~clk_sys_in;
    end
    // Roughly the 48 MHz pin clock
    initial begin
        clk48 = 1'b0;
        forever #10 clk48 = ~clk48;
    end

    chip_settings_readout i_chip_settings_readout (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
        .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
        .reg_rdata_out(reg_rdata), .req_valid_in(req_valid), .req_index_in(req_index), .req_byte_in(req_byte),
        .req_ready_out(req_ready), .rsp_valid_out(rsp_valid), .rsp_index_out(rsp_index), .rsp_byte_out(rsp_byte),
        .uart_rx_busy_in(busy[0]), .uart_tx_busy_in(busy[1]), .i2c_busy_in(busy[2]), .suspend_in(busy[3]),
        .usb_configured_in(busy[4]), .usb_clk_48_in(clk48), .uart_rx_activity_indicator_out(ind[0]),
        .uart_tx_activity_indicator_out(ind[1]), .i2c_activity_indicator_out(ind[2]),
        .suspend_indicator_out(ind[3]), .usb_configured_indicator_out(ind[4]),
        .general_purpose_pin_clock_out(gp_clk), .general_purpose_pin_clock_oe_out(gp_oe));

    host_model i_host_model (.clk_sys_in(clk_sys_in), .start_in(start), .cmd_in(cmd), .sub_in(sub),
        .ready_in(req_ready), .valid_out(req_valid), .index_out(req_index), .byte_out(req_byte));

    always @(posedge clk_sys_in) begin
        if (rsp_valid) begin
            reply[rsp_index] <= {24'h0, rsp_byte};
            rsp_total <= rsp_total + 1;
        end
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            tally_and_finish;
        end
    end

    task automatic tally_and_finish;
        $display("checked=%0d failures=%0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys_in);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_sys_in);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys_in);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask

    task automatic request(input logic [7:0] c, input logic [7:0] s, input logic want);
        int base;
        @(posedge clk_sys_in);
        cmd <= c;
        sub <= s;
        start <= 1'b1;
        @(posedge clk_sys_in);
        start <= 1'b0;
        base = rsp_total;
        for (int n = 0; n < 300 && (rsp_total - base) < 64; n++) @(posedge clk_sys_in);
        repeat (2) @(posedge clk_sys_in);
        chk(32'(rsp_total - base), want ? 32'h40 : 32'h0);
    endtask

    task automatic t_reset_regs;
        rd(8'h00, 32'h0);
        rd(8'h04, 32'h0);
        rd(8'h08, 32'h0);
        rd(8'h0c, 32'h0);
        rd(8'h20, 32'h0);
        $display("reset values done");
    endtask

    task automatic t_reply;
        wr(8'h00, 32'ha9);
        wr(8'h04, 32'hffffff35);
        wr(8'h08, 32'hb7);
        rd(8'h04, 32'h15);
        request(8'hb0, 8'h00, 1'b1);
        chk(reply[0], 32'hb0);
        chk(reply[1], 32'h00);
        chk(reply[2], 32'h0a);
        chk(reply[4], 32'ha9);
        chk(reply[5], 32'h15);
        chk(reply[6], 32'hb7);
        for (int i = 7; i < 64; i++) chk(reply[i], 32'h0);
        $display("settings reply done");
    endtask

    task automatic t_unsupp;
        request(8'hb0, 8'h03, 1'b1);
        chk(reply[0], 32'hb0);
        chk(reply[1], 32'h01);
        chk(reply[4], 32'h00);
        request(8'h10, 8'h00, 1'b0);
        rd(8'h14, 32'h2);
        $display("unsupported request done");
    endtask

    task automatic t_indicators;
        int toggles;
        logic prev;
        toggles = 0;
        wr(8'h0c, 32'hf);
        busy <= 5'h1f;
        repeat (6) @(posedge clk_sys_in);
        #1 chk({27'h0, ind}, 32'h15);
        chk({31'h0, gp_oe}, 32'h1);
        prev = gp_clk;
        for (int n = 0; n < 300; n++) begin
            @(posedge clk_sys_in);
            if (gp_clk !== prev) toggles++;
            prev = gp_clk;
        end
        chk({31'h0, toggles != 0}, 32'h1);
        busy <= 5'h00;
        repeat (6) @(posedge clk_sys_in);
        #1 chk({27'h0, ind}, 32'h0a);
        wr(8'h0c, 32'h0);
        busy <= 5'h1f;
        repeat (6) @(posedge clk_sys_in);
        #1 chk({27'h0, ind}, 32'h09);
        rd(8'h10, 32'h1f24);
        busy <= 5'h00;
        $display("indicator levels done");
    endtask

    task automatic t_lock;
        wr(8'h00, 32'h02);
        wr(8'h00, 32'h00);
        rd(8'h00, 32'h02);
        $display("lock done");
    endtask

    initial begin
        sys_rst_in = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        start = 1'b0;
        cmd = 8'h00;
        sub = 8'h00;
        busy = 5'h00;
        repeat (16) @(posedge clk_sys_in);
        sys_rst_in <= 1'b0;
        t_reset_regs;
        t_reply;
        t_unsupp;
        t_indicators;
        t_lock;
        tally_and_finish;
    end
endmodule
